// file: hw/gpio_pkg.sv
// Notes on behaviour
// - latch register reads the latches; pin value register reads sampled pins
// - writing the pin value register loads the output latch like a latch write
// - bit set/clear writes read the pins, modify bits, store into the latch
// - six pins, each with direction and pin value bits; pin 3 has no latch bit, it reads 0
// - direction 1 turns the driver off; 0 drives the selected value
// - pin 3 is input only; its direction bit always reads 1
// - direction still rules analog pins; analog pins read 0 as pin value
// - analog select disables the digital input, so digital reads give 0
// - analog select never blocks a digital output
// - every implemented analog select bit is set by reset
// - open-drain bit set: output only sinks; clear: push-pull
// - slew bit set limits the pin slew rate; clear gives full rate
// - threshold bit picks schmitt or ttl for reads and change detection
// - an enabled peripheral owns the pin output; the pin stays readable
// - steering never touches direction; unselected pin is left alone
// - steering bit 7 takes serial receive from pin 5 when set, else pin 1
// - bit 6 puts wave a on pin 5 or 2; bit 5 puts wave b on 4 or 0
// - bit 3 takes timer gate from pin 3 or pin 4; bit 4 reads 0
// - bit 2 puts serial transmit on pin 4 when set, else pin 0
// - bit 1 puts pulse two on pin 4 or 0; bit 0 pulse one on 5 or 1
// - highest priority enabled function owns a pin; the latch is lowest
package gpio_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_PIN_VALUE = 4'h0;
   localparam logic [3:0] OFS_PIN_DIRECTION = 4'h1;
   localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h2;
   localparam logic [3:0] OFS_ANALOG_SELECT = 4'h3;
   localparam logic [3:0] OFS_OPEN_DRAIN = 4'h4;
   localparam logic [3:0] OFS_SLEW_LIMIT = 4'h5;
   localparam logic [3:0] OFS_INPUT_THRESHOLD = 4'h6;
   localparam logic [3:0] OFS_ALT_PIN_SELECT = 4'h7;
   localparam logic [3:0] OFS_PIN_VALUE_SET = 4'h8;
   localparam logic [3:0] OFS_PIN_VALUE_CLEAR = 4'h9;
   // ****************************************
   // implemented bits and reset values
   // ****************************************
   localparam logic [5:0] PIN_MASK = 6'h37;
   localparam logic [5:0] ANALOG_MASK = 6'h17;
   localparam logic [7:0] ALT_MASK = 8'hef;
   localparam logic [5:0] DIR_RST = 6'h3f;
   localparam logic [5:0] ANALOG_RST = 6'h17;
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [5:0] OPEN_DRAIN_RST = 6'h00;
   localparam logic [5:0] SLEW_RST = 6'h00;
   localparam logic [5:0] THRESHOLD_RST = 6'h00;
   localparam logic [7:0] ALT_RST = 8'h00;
   // ****************************************
   // steering bit positions
   // ****************************************
   localparam int SEL_RX = 7;
   localparam int SEL_WAVE_A = 6;
   localparam int SEL_WAVE_B = 5;
   localparam int SEL_GATE = 3;
   localparam int SEL_TX = 2;
   localparam int SEL_P2 = 1;
   localparam int SEL_P1 = 0;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic wave_a_en;
      logic wave_a;
      logic wave_b_en;
      logic wave_b;
      logic tx_en;
      logic tx;
      logic p1_en;
      logic p1;
      logic p2_en;
      logic p2;
   } periph_drive_t;
   typedef struct packed {
      logic serial_rx;
      logic timer_gate;
   } periph_sense_t;
   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] lat;
      logic [5:0] ansel;
      logic [5:0] od;
      logic [5:0] slew;
      logic [5:0] inlvl;
      logic [7:0] alt;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] prev;
      logic [5:0] change;
      logic [5:0] pin_out;
      logic [5:0] pin_oe_n;
      logic [7:0] rdata;
      periph_sense_t sense;
   } state_t;
   localparam state_t STATE_RST = '{dir: DIR_RST, lat: LATCH_RST,
      ansel: ANALOG_RST, od: OPEN_DRAIN_RST, slew: SLEW_RST,
      inlvl: THRESHOLD_RST, alt: ALT_RST, pin_oe_n: 6'h3f,
      default: '0};
endpackage

// file: hw/gpio_port.sv
`timescale 1ns/1ps
module gpio_port (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // register port
   input wire gpio_pkg::bus_req_t i_bus,
   output logic [7:0] o_rdata,
   // peripheral side
   input wire gpio_pkg::periph_drive_t i_drive,
   output gpio_pkg::periph_sense_t o_sense,
   // pad side
   input wire logic [5:0] i_pin_schmitt,
   input wire logic [5:0] i_pin_ttl,
   output logic [5:0] o_pin_out,
   output logic [5:0] o_pin_oe_n,
   output logic [5:0] o_slew_limit,
   output logic [5:0] o_analog_mode,
   output logic [5:0] o_pin_change
);

   // ****************************************
   // state
   // ****************************************
   gpio_pkg::state_t st_ff;
   gpio_pkg::state_t nxt_st;
   logic [5:0] seen;
   logic [5:0] val;
   logic [5:0] wmask;
   logic [7:0] alt;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= gpio_pkg::STATE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      alt = st_ff.alt;
      wmask = i_bus.wdata[5:0] & gpio_pkg::PIN_MASK;
      // threshold chosen before the synchroniser, so one choice
      // feeds both reads and change detection
      for (int i = 0; i < 6; i++) begin
         nxt_st.sync1[i] = st_ff.inlvl[i] ? i_pin_schmitt[i]
                                          : i_pin_ttl[i];
      end
      nxt_st.sync2 = st_ff.sync1;
      seen = st_ff.sync2 & ~st_ff.ansel;
      nxt_st.prev = seen;
      nxt_st.change = seen ^ st_ff.prev;

      // peripheral inputs follow the steering bits
      nxt_st.sense.serial_rx = alt[gpio_pkg::SEL_RX] ? seen[5]
                                                     : seen[1];
      nxt_st.sense.timer_gate = alt[gpio_pkg::SEL_GATE] ? seen[3]
                                                        : seen[4];

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            gpio_pkg::OFS_PIN_VALUE: begin
               nxt_st.lat = wmask;
            end
            gpio_pkg::OFS_OUTPUT_LATCH: begin
               nxt_st.lat = wmask;
            end
            gpio_pkg::OFS_PIN_VALUE_SET: begin
               nxt_st.lat = (seen | i_bus.wdata[5:0])
                            & gpio_pkg::PIN_MASK;
            end
            gpio_pkg::OFS_PIN_VALUE_CLEAR: begin
               nxt_st.lat = seen & ~i_bus.wdata[5:0]
                            & gpio_pkg::PIN_MASK;
            end
            gpio_pkg::OFS_PIN_DIRECTION: begin
               // pin 3 has no driver, so its bit stays 1
               nxt_st.dir = wmask | ~gpio_pkg::PIN_MASK;
            end
            gpio_pkg::OFS_ANALOG_SELECT: begin
               nxt_st.ansel = i_bus.wdata[5:0]
                              & gpio_pkg::ANALOG_MASK;
            end
            gpio_pkg::OFS_OPEN_DRAIN: begin
               nxt_st.od = wmask;
            end
            gpio_pkg::OFS_SLEW_LIMIT: begin
               nxt_st.slew = wmask;
            end
            gpio_pkg::OFS_INPUT_THRESHOLD: begin
               // changing this live may fake an edge on the pin
               nxt_st.inlvl = wmask;
            end
            gpio_pkg::OFS_ALT_PIN_SELECT: begin
               nxt_st.alt = i_bus.wdata & gpio_pkg::ALT_MASK;
            end
            default: begin
               nxt_st.lat = st_ff.lat;
            end
         endcase
      end

      // register reads: data stands only in the cycle after the strobe
      nxt_st.rdata = 8'h00;
      if (i_bus.rd) begin
         case (i_bus.addr)
            gpio_pkg::OFS_PIN_VALUE: begin
               nxt_st.rdata = {2'h0, seen};
            end
            gpio_pkg::OFS_OUTPUT_LATCH: begin
               nxt_st.rdata = {2'h0, st_ff.lat};
            end
            gpio_pkg::OFS_PIN_DIRECTION: begin
               nxt_st.rdata = {2'h0, st_ff.dir};
            end
            gpio_pkg::OFS_ANALOG_SELECT: begin
               nxt_st.rdata = {2'h0, st_ff.ansel};
            end
            gpio_pkg::OFS_OPEN_DRAIN: begin
               nxt_st.rdata = {2'h0, st_ff.od};
            end
            gpio_pkg::OFS_SLEW_LIMIT: begin
               nxt_st.rdata = {2'h0, st_ff.slew};
            end
            gpio_pkg::OFS_INPUT_THRESHOLD: begin
               nxt_st.rdata = {2'h0, st_ff.inlvl};
            end
            gpio_pkg::OFS_ALT_PIN_SELECT: begin
               nxt_st.rdata = st_ff.alt;
            end
            default: begin
               nxt_st.rdata = 8'h00;
            end
         endcase
      end

      // output selection: lowest priority first, so later
      // assignments (higher priority) win
      val = st_ff.lat;
      if (i_drive.p2_en && !alt[gpio_pkg::SEL_P2]) begin
         val[0] = i_drive.p2;
      end
      if (i_drive.tx_en && !alt[gpio_pkg::SEL_TX]) begin
         val[0] = i_drive.tx;
      end
      if (i_drive.wave_b_en && !alt[gpio_pkg::SEL_WAVE_B]) begin
         val[0] = i_drive.wave_b;
      end
      if (i_drive.p1_en && !alt[gpio_pkg::SEL_P1]) begin
         val[1] = i_drive.p1;
      end
      if (i_drive.wave_a_en && !alt[gpio_pkg::SEL_WAVE_A]) begin
         val[2] = i_drive.wave_a;
      end
      if (i_drive.p2_en && alt[gpio_pkg::SEL_P2]) begin
         val[4] = i_drive.p2;
      end
      if (i_drive.tx_en && alt[gpio_pkg::SEL_TX]) begin
         val[4] = i_drive.tx;
      end
      if (i_drive.wave_b_en && alt[gpio_pkg::SEL_WAVE_B]) begin
         val[4] = i_drive.wave_b;
      end
      if (i_drive.p1_en && alt[gpio_pkg::SEL_P1]) begin
         val[5] = i_drive.p1;
      end
      if (i_drive.wave_a_en && alt[gpio_pkg::SEL_WAVE_A]) begin
         val[5] = i_drive.wave_a;
      end

      // driver: direction and open drain gate it, analog select does not
      for (int i = 0; i < 6; i++) begin
         nxt_st.pin_out[i] = val[i] & ~st_ff.od[i];
         nxt_st.pin_oe_n[i] = st_ff.dir[i]
                              | (st_ff.od[i] & val[i]);
      end
      nxt_st.pin_oe_n[3] = 1'b1;
      nxt_st.pin_out[3] = 1'b0;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_rdata = st_ff.rdata;
   assign o_sense = st_ff.sense;
   assign o_pin_out = st_ff.pin_out;
   assign o_pin_oe_n = st_ff.pin_oe_n;
   assign o_slew_limit = st_ff.slew;
   assign o_analog_mode = st_ff.ansel;
   assign o_pin_change = st_ff.change;

   // ****************************************
   // checks
   // ****************************************
   pin3_undriven_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      o_pin_oe_n[3] && st_ff.dir[3])
      else $error("pin 3 driver enabled");

   dir3_reads_one_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_bus.rd && i_bus.addr == gpio_pkg::OFS_PIN_DIRECTION
      |=> o_rdata[3] && o_rdata[7:6] == 2'h0)
      else $error("direction bit 3 not read as one");

   value_write_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_bus.wr && i_bus.addr == gpio_pkg::OFS_PIN_VALUE
      |=> st_ff.lat == ($past(i_bus.wdata[5:0]) & gpio_pkg::PIN_MASK))
      else $error("pin value write missed the latch");

   set_rmw_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_bus.wr && i_bus.addr == gpio_pkg::OFS_PIN_VALUE_SET
      |=> st_ff.lat == (($past(seen) | $past(i_bus.wdata[5:0]))
                        & gpio_pkg::PIN_MASK))
      else $error("bit set did not merge pin levels");

   analog_reads_zero_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_bus.rd && i_bus.addr == gpio_pkg::OFS_PIN_VALUE
      |=> (o_rdata[5:0] & $past(st_ff.ansel)) == 6'h00)
      else $error("analog pin read as one");

   analog_reset_a: assert property (
      @(posedge i_clock)
      $fell(i_rst) |-> st_ff.ansel == gpio_pkg::ANALOG_RST)
      else $error("analog select not set after reset");

   latch_drives_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      !st_ff.dir[1] && !st_ff.od[1]
      && !(i_drive.p1_en && !st_ff.alt[gpio_pkg::SEL_P1])
      |=> !o_pin_oe_n[1] && o_pin_out[1] == $past(st_ff.lat[1]))
      else $error("pin 1 not driving its latch");

   open_drain_low_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      $past(st_ff.od[0]) |-> !o_pin_out[0])
      else $error("open drain pin sourced current");

   steer_wave_a_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_drive.wave_a_en && st_ff.alt[gpio_pkg::SEL_WAVE_A]
      && !st_ff.dir[5] && !st_ff.od[5] && !st_ff.od[2]
      |=> o_pin_out[5] == $past(i_drive.wave_a)
          && o_pin_out[2] == $past(st_ff.lat[2]))
      else $error("wave a steering wrong");

   rx_route_a: assert property (
      @(posedge i_clock) disable iff (i_rst)
      ##1 o_sense.serial_rx == $past(st_ff.alt[gpio_pkg::SEL_RX]
                                     ? seen[5] : seen[1]))
      else $error("serial receive taken from wrong pin");

endmodule // gpio_port

// file: test/pad_model.sv
`timescale 1ns/1ps
module pad_model (
   // device side
   input wire logic [5:0] i_pin_out,
   input wire logic [5:0] i_pin_oe_n,
   // far side drive
   input wire logic [5:0] i_ext_val,
   input wire logic [5:0] i_ext_en,
   input wire logic [5:0] i_ttl_flip,
   // comparator levels
   output logic [5:0] o_schmitt,
   output logic [5:0] o_ttl
);
   logic [5:0] level;
   // a pin nobody drives floats up to the weak pull-up
   assign level = (~i_pin_oe_n & i_pin_out)
      | (i_pin_oe_n & (~i_ext_en | i_ext_val));
   assign o_schmitt = level;
   // ttl comparator may disagree near the switching band
   assign o_ttl = level ^ i_ttl_flip;
endmodule // pad_model

// file: test/test_six_bit_gpio_with_pin_steering.sv
`timescale 1ns/1ps
module test_six_bit_gpio_with_pin_steering;
   // ****************************************
   // wiring
   // ****************************************
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   gpio_pkg::bus_req_t bus = '0;
   gpio_pkg::periph_drive_t drv = '0;
   gpio_pkg::periph_sense_t sense;
   logic [7:0] rdata, alt = '0, d;
   logic [5:0] schmitt, ttl, pin_out, oe_n, slew, amode, change;
   logic [5:0] ext_val = '0, ext_en = 6'h3f, flip = '0;
   logic [5:0] dir = '0, lat = '0, od = '0, ansel = '0, thr = '0;
   logic [7:0] rst_v [7] = '{8'h3f, 8'h00, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ful_v [7] = '{8'h3f, 8'h37, 8'h17, 8'h37, 8'h37, 8'h37, 8'hef};
   int failures = 0;
   int tests_run = 0;
   int seed = 32'hfc41;
   int n;
   always #2 i_clock = ~i_clock;
   gpio_port gpio_port_inst (.i_clock(i_clock), .i_rst(i_rst), .i_bus(bus),
      .o_rdata(rdata), .i_drive(drv), .o_sense(sense),
      .i_pin_schmitt(schmitt), .i_pin_ttl(ttl), .o_pin_out(pin_out),
      .o_pin_oe_n(oe_n), .o_slew_limit(slew), .o_analog_mode(amode),
      .o_pin_change(change));
   pad_model pad_model_inst (.i_pin_out(pin_out), .i_pin_oe_n(oe_n),
      .i_ext_val(ext_val), .i_ext_en(ext_en), .i_ttl_flip(flip),
      .o_schmitt(schmitt), .o_ttl(ttl));
   // ****************************************
   // expectations
   // ****************************************
   // lowest priority first, so higher functions overwrite
   function automatic logic [5:0] f_val();
      logic [5:0] v;
      v = lat;
      if (drv.p2_en) v[alt[1] ? 4 : 0] = drv.p2;
      if (drv.tx_en) v[alt[2] ? 4 : 0] = drv.tx;
      if (drv.wave_b_en) v[alt[5] ? 4 : 0] = drv.wave_b;
      if (drv.p1_en) v[alt[0] ? 5 : 1] = drv.p1;
      if (drv.wave_a_en) v[alt[6] ? 5 : 2] = drv.wave_a;
      return v;
   endfunction
   function automatic logic [5:0] f_oen();
      return dir | 6'h08 | (od & f_val());
   endfunction
   function automatic logic [5:0] f_pv();
      logic [5:0] l;
      l = (~f_oen() & f_val()) | (f_oen() & (~ext_en | ext_val));
      return (l ^ (flip & ~thr)) & ~ansel;
   endfunction
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clock) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge i_clock) bus <= '0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
      input string nm);
      @(posedge i_clock) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clock) bus <= '0;
      #1 chk(nm, e, rdata);
   endtask
   task automatic settle();
      repeat (5) @(posedge i_clock);
      #1;
   endtask
   task automatic check_port();
      logic [5:0] e, v, o, pv;
      e = f_oen();
      v = f_val() & ~e;
      o = pin_out & ~e;
      pv = f_pv();
      chk("oe_n", 8'(e), 8'(oe_n));
      chk("out", 8'(v), 8'(o));
      chk("amode", 8'(ansel), 8'(amode));
      rd_chk(gpio_pkg::OFS_PIN_VALUE, 8'(pv), "pins");
      rd_chk(gpio_pkg::OFS_OUTPUT_LATCH, 8'(lat), "latch");
      chk("rx", 8'(alt[7] ? pv[5] : pv[1]), 8'(sense.serial_rx));
      chk("gate", 8'(alt[3] ? pv[3] : pv[4]), 8'(sense.timer_gate));
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd_chk(4'(i + 1), rst_v[i], "reset");
      end
      rd_chk(4'ha, 8'h00, "unmapped");
      for (int i = 0; i < 7; i++) wr(4'(i + 1), 8'hff);
      for (int i = 0; i < 7; i++) begin
         rd_chk(4'(i + 1), ful_v[i], "full");
      end
      chk("slew", 8'h37, {2'h0, slew});
      for (int i = 0; i < 7; i++) wr(4'(i + 1), 8'h00);
      rd_chk(gpio_pkg::OFS_PIN_DIRECTION, 8'h08, "dir");
      chk("slew", 8'h00, {2'h0, slew});
      for (int i = 0; i < 60; i++) begin
         // thresholds move only while the peripherals are idle
         @(posedge i_clock) drv <= '0;
         // pin 3 has no threshold bit, so it always stays on ttl
         d = 8'($random(seed));
         thr = d[5:0] & 6'h37;
         wr(gpio_pkg::OFS_INPUT_THRESHOLD, d);
         dir = 6'($random(seed));
         od = 6'($random(seed));
         ansel = 6'($random(seed)) & 6'h17;
         d = 8'($random(seed));
         alt = d & 8'hef;
         wr(gpio_pkg::OFS_PIN_DIRECTION, {2'h0, dir});
         wr(gpio_pkg::OFS_OPEN_DRAIN, {2'h0, od});
         wr(gpio_pkg::OFS_ANALOG_SELECT, {2'h0, ansel});
         wr(gpio_pkg::OFS_ALT_PIN_SELECT, d);
         @(posedge i_clock);
         drv <= 10'($random(seed));
         ext_val <= 6'($random(seed));
         ext_en <= 6'($random(seed));
         flip <= 6'($random(seed));
         settle();
         d = 8'($random(seed));
         case (i % 4)
            0: lat = d[5:0] & 6'h37;
            1: lat = d[5:0] & 6'h37;
            2: lat = (f_pv() | d[5:0]) & 6'h37;
            default: lat = f_pv() & ~d[5:0] & 6'h37;
         endcase
         wr((i % 4 == 0) ? gpio_pkg::OFS_OUTPUT_LATCH : (i % 4 == 1)
            ? gpio_pkg::OFS_PIN_VALUE : (i % 4 == 2)
            ? gpio_pkg::OFS_PIN_VALUE_SET : gpio_pkg::OFS_PIN_VALUE_CLEAR, d);
         settle();
         check_port();
      end
      @(posedge i_clock) ext_en <= 6'h3f;
      settle();
      @(posedge i_clock) ext_val[3] <= ~ext_val[3];
      n = 0;
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clock);
         #1 if (change[3] === 1'b1) n++;
      end
      chk("change", 8'h01, 8'(n));
      // second reset in mid-run: controls must fall back to defaults
      @(posedge i_clock) i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd_chk(gpio_pkg::OFS_ANALOG_SELECT, 8'h17, "reset2");
      rd_chk(gpio_pkg::OFS_PIN_DIRECTION, 8'h3f, "reset2");
      rd_chk(gpio_pkg::OFS_OUTPUT_LATCH, 8'h00, "reset2");
      chk("amode", 8'h17, 8'(amode));
      print_verdict();
   end
endmodule // test_six_bit_gpio_with_pin_steering
